// >>> core/rdt_top.sv
// Six 16-bit reload down-count timers with an APB register slave.
// Assumes one clock pclk at 125 MHz; pins arrive asynchronous to it.
//
// Functional notes
// R1 - Each timer has its own 16-bit down-counter and 16-bit reload value.
// R2 - Prescaler divides input clock by 4, 16, 64 or 256.
// R3 - Six timers run independently; only input pins, source select and output enables are shared.
// R4 - Start value zero wraps to all ones first, longest period.
// R5 - Timeout equals prescaler ratio times reload, zero counting as 65536.
// R6 - Single-pass: at zero counting stops and run-enable clears itself.
// R7 - Host restarts a halted single-pass timer by writing run-enable to one.
// R8 - Continuous: at zero reload from reload bytes and keep counting.
// R9 - Count reads while running never disturb counting.
// R10 - Low count read latches high byte; host reads low before high.
// R11 - End-of-count flag sets only on the step from one to zero.
// R12 - Loading zero into the counter never sets the flag.
// R13 - Flag with interrupt enable raises the interrupt request.
// R14 - Reading the control register clears flag and interrupt request.
// R15 - Timers 0-3 pick system clock, real-time clock or an event pin.
// R16 - Real-time source counts on falling edges of the oscillator output.
// R17 - Event pin counting bypasses prescaler, one step per rising edge.
// R18 - Host keeps event rate below half the system clock.
// R19 - Event pin edge updates the counter on the fifth clock edge.
// R20 - Timers 4 and 5 toggle their output pin at each end of count.
// R21 - Timer output feature is off after reset until enabled.
// R22 - Control bits: enable 0, restart 1, divide 3:2, mode 4, irq enable 6.
// R23 - Reload bytes are write-only, sharing addresses with read-only count.
// R24 - Writing one to the restart bit loads reload into counter.
// R25 - Prescaler restarts from zero on enable or reload.
`include "rdt_consts.svh"
module rdt_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic event_pin_a,
    input wire logic event_pin_b,
    input wire logic rtc_osc_output,
    output logic [5:0] irq,
    output logic timer_out_pin_four,
    output logic timer_out_pin_five
);
    import rdt_pkg::*;

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Register hit for timer t, field f
    function automatic logic rdt_hit(input rdt_index_t idx, input int t, input int f);
        rdt_hit = (idx == 10'(`RDT_CTL_BASE + `RDT_STRIDE * t + f));
    endfunction

    // Prescaler terminal count from divide select
    function automatic rdt_byte_t rdt_term(input logic [1:0] sel);
        unique case (sel)
            2'h0: rdt_term = `RDT_TERM_4;
            2'h1: rdt_term = `RDT_TERM_16;
            2'h2: rdt_term = `RDT_TERM_64;
            2'h3: rdt_term = `RDT_TERM_256;
        endcase
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    logic [5:0] en_reg, rst_reg, mode_reg, ien_reg, flag_reg, irq_reg;
    logic [1:0] div_reg [6];
    rdt_count_t cnt_reg [6]; // R1
    rdt_count_t rld_reg [6];
    rdt_byte_t hold_reg [6];
    rdt_byte_t pre_reg [6];
    rdt_src_e src_reg [4];
    logic [1:0] tout_en_reg, tout_reg;
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic [2:0] a_sync_reg, b_sync_reg, r_sync_reg;
    logic [1:0] a_dly_reg, b_dly_reg;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic capture, commit, rd_cap, wr_do, mapped;
    rdt_index_t idx;
    logic [5:0] rd_ctl, rd_low, wr_ctl, wr_low, wr_high;
    rdt_byte_t rd_val;
    logic [7:0] wb;

    // Capture one cycle into access, finish on the next
    assign capture = psel & penable & ~pready_reg;
    assign commit = psel & penable & pready_reg;
    assign rd_cap = capture & ~pwrite;
    assign wr_do = commit & pwrite;
    assign idx = paddr[11:2];
    assign wb = pwdata[7:0];

    // Per-timer strobes and read mux
    always_comb begin
        mapped = (idx == `RDT_SRC_IDX) | (idx == `RDT_TOUT_IDX);
        rd_val = `RDT_BYTE_RST;
        rd_ctl = 6'h00;
        rd_low = 6'h00;
        wr_ctl = 6'h00;
        wr_low = 6'h00;
        wr_high = 6'h00;
        for (int i = 0; i < 6; i++) begin
            if (rdt_hit(idx, i, `RDT_OFS_CTL)) begin
                mapped = 1'b1;
                rd_ctl[i] = rd_cap;
                wr_ctl[i] = wr_do;
                rd_val = {flag_reg[i], ien_reg[i], 1'b0, mode_reg[i],
                          div_reg[i], rst_reg[i], en_reg[i]}; // R22
            end
            if (rdt_hit(idx, i, `RDT_OFS_LOW)) begin
                mapped = 1'b1;
                rd_low[i] = rd_cap;
                wr_low[i] = wr_do;
                rd_val = cnt_reg[i][7:0]; // R23
            end
            if (rdt_hit(idx, i, `RDT_OFS_HIGH)) begin
                mapped = 1'b1;
                wr_high[i] = wr_do;
                rd_val = hold_reg[i]; // R10
            end
        end
        if (idx == `RDT_SRC_IDX) begin
            rd_val = {src_reg[3], src_reg[2], src_reg[1], src_reg[0]};
        end
        if (idx == `RDT_TOUT_IDX) begin
            rd_val = {6'h00, tout_en_reg};
        end
    end

    // APB answer, registered so outputs come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= capture;
            pslverr_reg <= capture & ~mapped;
            if (rd_cap) begin
                prdata_reg <= mapped ? {24'h000000, rd_val} : 32'h00000000;
            end
        end
    end

    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    // Two flops before use; third stage only feeds edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_sync_reg <= 3'h0;
            b_sync_reg <= 3'h0;
            r_sync_reg <= 3'h0;
            a_dly_reg <= 2'h0;
            b_dly_reg <= 2'h0;
        end else begin
            a_sync_reg <= {a_sync_reg[1:0], event_pin_a};
            b_sync_reg <= {b_sync_reg[1:0], event_pin_b};
            r_sync_reg <= {r_sync_reg[1:0], rtc_osc_output};
            // Extra delay aligns event update with the fifth edge
            a_dly_reg <= {a_dly_reg[0], a_sync_reg[1] & ~a_sync_reg[2]}; // R19
            b_dly_reg <= {b_dly_reg[0], b_sync_reg[1] & ~b_sync_reg[2]}; // R19
        end
    end

    logic rtc_fall;
    assign rtc_fall = ~r_sync_reg[1] & r_sync_reg[2]; // R16

    // ****************************************************************
    // Tick generation
    // ****************************************************************
    logic [5:0] raw, evt, pre_end, tick, eoc, load, pre_clr;

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            raw[i] = 1'b1;
            evt[i] = 1'b0;
            if (i < 4) begin
                unique case (src_reg[i % 4])
                    RDT_SRC_RTC: raw[i] = rtc_fall; // R15
                    RDT_SRC_EVT: begin
                        raw[i] = 1'b0;
                        evt[i] = 1'b1; // R17
                    end
                    default: raw[i] = 1'b1;
                endcase
            end
            pre_end[i] = raw[i] & (pre_reg[i] == rdt_term(div_reg[i])); // R2
            tick[i] = en_reg[i] & (evt[i] ? ((i % 2 == 0) ? a_dly_reg[1] : b_dly_reg[1])
                                           : pre_end[i]); // R17
            eoc[i] = tick[i] & (cnt_reg[i] == 16'h0001); // R11
            load[i] = wr_ctl[i] & wb[`RDT_BIT_RST]; // R24
            pre_clr[i] = load[i] | (wr_ctl[i] & wb[`RDT_BIT_EN] & ~en_reg[i]); // R25
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    // Host write sets fields; single-pass halt clears enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg <= 6'h00;
            rst_reg <= 6'h00;
            mode_reg <= 6'h00;
            ien_reg <= 6'h00;
            div_reg <= '{default: 2'h0};
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (wr_ctl[i]) begin
                    en_reg[i] <= wb[`RDT_BIT_EN]; // R7
                    rst_reg[i] <= wb[`RDT_BIT_RST];
                    mode_reg[i] <= wb[`RDT_BIT_MODE];
                    ien_reg[i] <= wb[`RDT_BIT_IEN];
                    div_reg[i] <= wb[`RDT_DIV_HI:`RDT_DIV_LO]; // R22
                end else if (eoc[i] & ~mode_reg[i]) begin
                    en_reg[i] <= 1'b0; // R6
                end
            end
        end
    end

    // Source select and output enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tout_en_reg <= 2'h0; // R21
            src_reg <= '{default: RDT_SRC_SYS};
        end else begin
            if (wr_do & (idx == `RDT_TOUT_IDX)) begin
                tout_en_reg <= wb[1:0];
            end
            if (wr_do & (idx == `RDT_SRC_IDX)) begin
                for (int i = 0; i < 4; i++) begin
                    src_reg[i] <= rdt_src_e'(wb[2*i +: 2]); // R15
                end
            end
        end
    end

    // Reload bytes are write-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rld_reg <= '{default: `RDT_CNT_RST};
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (wr_low[i]) begin
                    rld_reg[i][7:0] <= wb; // R23
                end
                if (wr_high[i]) begin
                    rld_reg[i][15:8] <= wb; // R23
                end
            end
        end
    end

    // ****************************************************************
    // Prescaler and down-counter
    // ****************************************************************
    // Prescaler runs only while enabled so halted timers stay put
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= '{default: `RDT_BYTE_RST};
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (pre_clr[i] | pre_end[i]) begin
                    pre_reg[i] <= `RDT_BYTE_RST; // R25
                end else if (en_reg[i] & raw[i]) begin
                    pre_reg[i] <= pre_reg[i] + 8'h01; // R2
                end
            end
        end
    end

    // Reload write wins over a tick in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '{default: `RDT_CNT_RST};
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (load[i]) begin
                    cnt_reg[i] <= rld_reg[i]; // R24
                end else if (eoc[i] & mode_reg[i]) begin
                    cnt_reg[i] <= rld_reg[i]; // R8
                end else if (tick[i]) begin
                    cnt_reg[i] <= cnt_reg[i] - 16'h0001; // R4 R5
                end
            end
        end
    end

    // Low read latches high byte; no effect on counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_reg <= '{default: `RDT_BYTE_RST};
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (rd_low[i]) begin
                    hold_reg[i] <= cnt_reg[i][15:8]; // R10 R9
                end
            end
        end
    end

    // ****************************************************************
    // Flag, interrupt and timer output
    // ****************************************************************
    logic [5:0] flag_next;
    // Set beats the clear-on-read so no event is lost
    assign flag_next = eoc | (flag_reg & ~rd_ctl); // R14 R12

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 6'h00;
            irq_reg <= 6'h00;
        end else begin
            flag_reg <= flag_next; // R11
            irq_reg <= flag_next & ien_reg; // R13 R3
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tout_reg <= 2'h0;
        end else begin
            tout_reg <= tout_reg ^ (tout_en_reg & eoc[5:4]); // R20
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign timer_out_pin_four = tout_reg[0];
    assign timer_out_pin_five = tout_reg[1];

    // ****************************************************************
    // Checks
    // ****************************************************************
    for (genvar g = 0; g < 6; g++) begin : g_chk
        property p_single_halt;
            @(posedge pclk) disable iff (!presetn)
            (eoc[g] & ~mode_reg[g] & ~wr_ctl[g]) |=> (!en_reg[g] && cnt_reg[g] == 16'h0000);
        endproperty
        a_single_halt: assert property (p_single_halt) else $error("single pass not halted"); // R6
        // A host write in the reload cycle may legally stop the timer
        property p_cont_reload;
            @(posedge pclk) disable iff (!presetn)
            (eoc[g] & mode_reg[g] & ~wr_ctl[g])
                |=> (cnt_reg[g] == $past(rld_reg[g]) && en_reg[g]);
        endproperty
        a_cont_reload: assert property (p_cont_reload) else $error("continuous reload wrong"); // R8
        property p_flag_cause;
            @(posedge pclk) disable iff (!presetn)
            $rose(flag_reg[g]) |-> ($past(tick[g]) && $past(cnt_reg[g]) == 16'h0001);
        endproperty
        a_flag_cause: assert property (p_flag_cause) else $error("flag set without end of count"); // R11
        // Flag and request drop together at the capture edge
        property p_read_clear;
            @(posedge pclk) disable iff (!presetn)
            (rd_ctl[g] & ~eoc[g]) |=> (!flag_reg[g] && !irq[g]);
        endproperty
        a_read_clear: assert property (p_read_clear) else $error("control read did not clear"); // R14
        property p_irq_follow;
            @(posedge pclk) disable iff (!presetn)
            (flag_reg[g] & ien_reg[g] & ~rd_ctl[g]) |=> irq[g];
        endproperty
        a_irq_follow: assert property (p_irq_follow) else $error("interrupt not raised"); // R13
        property p_restart_load;
            @(posedge pclk) disable iff (!presetn)
            load[g] |=> (cnt_reg[g] == $past(rld_reg[g]) && pre_reg[g] == 8'h00);
        endproperty
        a_restart_load: assert property (p_restart_load) else $error("restart did not load"); // R24
        property p_hold_latch;
            @(posedge pclk) disable iff (!presetn)
            rd_low[g] |=> (hold_reg[g] == $past(cnt_reg[g][15:8]));
        endproperty
        a_hold_latch: assert property (p_hold_latch) else $error("high byte not latched"); // R10
        property p_count_step;
            @(posedge pclk) disable iff (!presetn)
            (!tick[g] && !load[g]) |=> $stable(cnt_reg[g]);
        endproperty
        a_count_step: assert property (p_count_step) else $error("count moved without tick"); // R9
    end

    property p_tout_toggle;
        @(posedge pclk) disable iff (!presetn)
        (eoc[4] & tout_en_reg[0]) |=> (timer_out_pin_four != $past(timer_out_pin_four));
    endproperty
    a_tout_toggle: assert property (p_tout_toggle) else $error("timer output did not toggle"); // R20
endmodule

// >>> core/rdt_consts.svh
// Register indices, field positions and reset values of the reload timers.
// Assumes inclusion by the timer package, the timer top and the bench; guarded.
`ifndef RDT_CONSTS_SVH
`define RDT_CONSTS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define RDT_CTL_BASE 10'h080
`define RDT_STRIDE 3
`define RDT_OFS_CTL 0
`define RDT_OFS_LOW 1
`define RDT_OFS_HIGH 2
`define RDT_SRC_IDX 10'h098
`define RDT_TOUT_IDX 10'h099

// ****************************************************************
// Control register fields
// ****************************************************************
`define RDT_BIT_EN 0
`define RDT_BIT_RST 1
`define RDT_DIV_LO 2
`define RDT_DIV_HI 3
`define RDT_BIT_MODE 4
`define RDT_BIT_IEN 6
`define RDT_BIT_FLAG 7

// ****************************************************************
// Prescaler terminal counts and reset values
// ****************************************************************
`define RDT_TERM_4 8'h03
`define RDT_TERM_16 8'h0f
`define RDT_TERM_64 8'h3f
`define RDT_TERM_256 8'hff
`define RDT_CNT_RST 16'h0000
`define RDT_BYTE_RST 8'h00

`endif

// >>> core/rdt_pkg.sv
// Types shared by the reload timer block.
// Assumes the constants header sits beside it.
package rdt_pkg;
    `include "rdt_consts.svh"

    // Input source choice of timers 0-3
    typedef enum logic [1:0] {
        RDT_SRC_SYS = 2'h0,
        RDT_SRC_RTC = 2'h1,
        RDT_SRC_EVT = 2'h2
    } rdt_src_e;

    typedef logic [15:0] rdt_count_t;
    typedef logic [7:0] rdt_byte_t;
    typedef logic [9:0] rdt_index_t;
endpackage

// >>> test/rdt_host_model.sv
// APB master that stands in for the host processor on the register bus.
// Assumes pclk from the bench; every request signal moves just after a rising edge.
`include "rdt_consts.svh"
module rdt_host_model
    import rdt_pkg::*;
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic hang
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Idle bus
    // ****************************************************************
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        hang = 1'b0;
    end

    // ****************************************************************
    // One whole transfer
    // ****************************************************************
    // Request held until pready is sampled high or 32 cycles pass; no fixed latency assumed
    task automatic xfer(input logic wr, input rdt_index_t idx, input rdt_byte_t wd,
                        output rdt_byte_t rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 32);
        if (pready !== 1'b1) begin
            hang <= 1'b1;
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show garbage, so a slave latching late is caught
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask
endmodule

// >>> test/tb.sv
// Self-checking bench for the six reload timers, registers reached over APB.
// Assumes the host model drives the bus; event and oscillator pins are driven here.
`include "rdt_consts.svh"
module tb;
    import rdt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hang;
    logic event_pin_a, event_pin_b, rtc_osc_output, timer_out_pin_four, timer_out_pin_five;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [5:0] irq;
    wire [7:0] obs = {timer_out_pin_five, timer_out_pin_four, irq};
    int failures, num_checks, st, t1, t2;
    int cyc = 0;
    rdt_byte_t rd;
    logic err;

    rdt_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_pin_a(event_pin_a), .event_pin_b(event_pin_b),
        .rtc_osc_output(rtc_osc_output), .irq(irq), .timer_out_pin_four(timer_out_pin_four),
        .timer_out_pin_five(timer_out_pin_five));
    rdt_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hang(hang));

    // ****************************************************************
    // Clock, cycle stamp and hang guard
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;
    always @(posedge pclk) begin
        if (hang === 1'b1) begin
            test_done();
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic test_done();
        // A bus timeout fails the run like any mismatch
        if (failures == 0 && num_checks > 0 && hang !== 1'b1) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp_byte(input rdt_byte_t got, input rdt_byte_t exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
        end
    endtask
    task automatic cmp_int(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            failures++;
            $display("unexpected at %0t: cycles %0d, wanted %0d", $time, got, exp);
        end
    endtask
    function automatic rdt_index_t idx(input int t, input int ofs);
        return rdt_index_t'(`RDT_CTL_BASE + `RDT_STRIDE * t + ofs);
    endfunction
    task automatic wr(input rdt_index_t i, input rdt_byte_t d);
        host.xfer(1'b1, i, d, rd, err);
    endtask
    task automatic rd_exp(input rdt_index_t i, input rdt_byte_t exp);
        host.xfer(1'b0, i, 8'h00, rd, err);
        cmp_byte(rd, exp);
    endtask
    // Reload both bytes, then control; stamp is the edge the control write lands
    task automatic start(input int t, input rdt_byte_t c, input rdt_byte_t rl);
        wr(idx(t, `RDT_OFS_LOW), rl);
        wr(idx(t, `RDT_OFS_HIGH), 8'h00);
        wr(idx(t, `RDT_OFS_CTL), c);
        st = cyc + 1;
    endtask
    // Bounded wait for an observed output to change
    task automatic wait_chg(input int k, output int s);
        logic v;
        int n;
        v = obs[k];
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (obs[k] === v && n < 3000);
        if (n >= 3000) begin
            failures++;
            test_done();
        end
        s = cyc;
    endtask
    // Pin trains with a 4-cycle period, well below half the clock rate; stamp is launch edge
    task automatic pins(input logic osc, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            if (osc) rtc_osc_output <= 1'b0;
            else begin
                event_pin_a <= 1'b1;
                event_pin_b <= 1'b1;
            end
            st = cyc + 1;
            repeat (2) @(posedge pclk);
            rtc_osc_output <= 1'b1;
            event_pin_a <= 1'b0;
            event_pin_b <= 1'b0;
            @(posedge pclk);
        end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        presetn = 1'b0;
        event_pin_a = 1'b0;
        event_pin_b = 1'b0;
        rtc_osc_output = 1'b1;
        failures = 0;
        num_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        cmp_byte(obs, 8'h00);
        for (int t = 0; t < 6; t++) rd_exp(idx(t, `RDT_OFS_CTL), 8'h00);
        host.xfer(1'b0, 10'h09a, 8'h00, rd, err);
        cmp_bit(err, 1'b1);
        cmp_byte(rd, 8'h00);
        // Single pass, divide by 4, interrupt on; flag edge minus restart edge
        start(0, 8'h43, 8'h03);
        wait_chg(0, t1);
        cmp_int(t1 - st, 4 * 3);
        cmp_byte(obs, 8'h01);
        rd_exp(idx(0, `RDT_OFS_CTL), 8'hc2);
        repeat (2) @(posedge pclk);
        cmp_bit(irq[0], 1'b0);
        rd_exp(idx(0, `RDT_OFS_LOW), 8'h00);
        rd_exp(idx(0, `RDT_OFS_HIGH), 8'h00);
        // Every prescaler tap, restarted after each halt
        for (int d = 0; d < 4; d++) begin
            start(1, rdt_byte_t'(8'h43 | (d << 2)), 8'h02);
            wait_chg(1, t1);
            cmp_int(t1 - st, (4 << (2 * d)) * 2);
            rd_exp(idx(1, `RDT_OFS_CTL), rdt_byte_t'(8'hc2 | (d << 2)));
        end
        // Zero start value: wrap, no flag, high byte latched by low read
        start(3, 8'h03, 8'h00);
        rd_exp(idx(3, `RDT_OFS_CTL), 8'h03);
        host.xfer(1'b0, idx(3, `RDT_OFS_LOW), 8'h00, rd, err);
        repeat (1100) @(posedge pclk);
        rd_exp(idx(3, `RDT_OFS_HIGH), 8'hff);
        wr(idx(3, `RDT_OFS_CTL), 8'h00);
        // Continuous timers 4 and 5, output pin for timer 4 only
        wr(`RDT_TOUT_IDX, 8'h01);
        start(4, 8'h13, 8'h04);
        start(5, 8'h53, 8'h04);
        wait_chg(5, t1);
        rd_exp(idx(5, `RDT_OFS_CTL), 8'hd3);
        host.xfer(1'b0, idx(5, `RDT_OFS_LOW), 8'h00, rd, err);
        rd_exp(idx(5, `RDT_OFS_HIGH), 8'h00);
        wait_chg(5, t2);
        cmp_int(t2 - t1, 16);
        wait_chg(6, t1);
        wait_chg(6, t2);
        cmp_int(t2 - t1, 16);
        cmp_bit(timer_out_pin_five, 1'b0);
        cmp_bit(irq[4], 1'b0);
        wr(idx(4, `RDT_OFS_CTL), 8'h00);
        wr(idx(5, `RDT_OFS_CTL), 8'h00);
        // Event pins for timers 0 and 1, oscillator for timer 2
        wr(`RDT_SRC_IDX, 8'h1a);
        start(0, 8'h43, 8'h02);
        start(1, 8'h43, 8'h02);
        pins(1'b0, 2);
        wait_chg(0, t1);
        cmp_int(t1 - st, 5);
        cmp_bit(irq[1], 1'b1);
        // Two-flop synchroniser puts the oscillator step on the third edge
        start(2, 8'h43, 8'h01);
        pins(1'b1, 4);
        wait_chg(2, t1);
        cmp_int(t1 - st, 3);
        test_done();
    end
endmodule
